/* asl_consts.svh */
// register offsets, field positions, reset values and codes of the scan and limit control
//
// How it works
// - sixteen low channel enables, reset zero
// - bit0 channel16 temperature, bit1 channel17 self-test
// - enabled channels converted lowest number first
// - start ignored when no channel enabled
// - consecutive scans wait interval register cycles
// - interval counts after last channel converted
// - clock select 111 forces zero interval
// - two-bit limit condition selects match test
// - match on channels 0-16 sets channel status, raises interrupt
// - limit disabled leaves status untouched
// - upper limit bits 15:6, resets ffc0
// - lower limit bits 15:6, resets zero
// - reference select, code 11 acts 00
// - interrupt per scan or per channel
// - limit enabled: interrupt only from matches
// - five-bit trigger source selection
// - test field replaces analog input
// - self-test results go to result register
// - single scan clears run flag automatically
// - trigger enable gates trigger starts
// - scan mode: single or repeated scans
// - status cleared only by writing one
`ifndef ASL_CONSTS_SVH
`define ASL_CONSTS_SVH

// register byte addresses on the 16-bit register port
`define ASL_OFF_SELF_TEST     16'hf0ba
`define ASL_OFF_RESULT        16'hf820
`define ASL_OFF_STATUS_LOW    16'hf824
`define ASL_OFF_STATUS_HIGH   16'hf826
`define ASL_OFF_MODE          16'hf828
`define ASL_OFF_CONTROL       16'hf82a
`define ASL_OFF_EN_LOW        16'hf82c
`define ASL_OFF_EN_HIGH       16'hf82e
`define ASL_OFF_INTERVAL      16'hf832
`define ASL_OFF_LIMIT_MODE    16'hf834
`define ASL_OFF_UPPER         16'hf836
`define ASL_OFF_LOWER         16'hf838
`define ASL_OFF_REF_CTRL      16'hf83a
`define ASL_OFF_INT_MODE      16'hf83c
`define ASL_OFF_TRIG_SEL      16'hf83e

// reset values of the stored fields
`define ASL_RST_UPPER         10'h3ff
`define ASL_RST_LOWER         10'h000

// field positions
`define ASL_BIT_RUN           0
`define ASL_BIT_TRIG_EN       1
`define ASL_BIT_REPEAT        0
`define ASL_MODE_CLK_LSB      1
`define ASL_LIM_EN_BIT        0
`define ASL_LIM_COND_LSB      8
`define ASL_LIMIT_LSB         6
`define ASL_REF_SEL_LSB       4
`define ASL_REF_EN_BIT        0

// codes
`define ASL_CLK_SLOW          3'h7
`define ASL_TRG_TMH0          5'h00
`define ASL_TRG_TMH1          5'h01
`define ASL_TRG_FTM0          5'h04
`define ASL_TRG_FTM1          5'h05
`define ASL_TRG_TBC           5'h08
`define ASL_LAST_CHANNEL      5'h11

`endif

/* asl_pkg.sv */
// types shared by the scan and limit control and its surroundings
package asl_pkg;

  typedef enum logic [1:0] {
    st_idle,
    st_launch,
    st_busy,
    st_gap
  } asl_state_t;

  // software register port
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } asl_bus_req_t;

  // request toward the analog core
  typedef struct packed {
    logic        start;
    logic [4:0]  channel;
    logic [1:0]  test_sel;
    logic [1:0]  ref_sel;
    logic        ref_en;
    logic [2:0]  clk_sel;
    logic [3:0]  sample_sel;
    logic        discharge;
  } asl_conv_req_t;

  // answer from the analog core
  typedef struct packed {
    logic        done;
    logic [15:0] result;
  } asl_conv_rsp_t;

  // trigger pulses from neighbouring timers
  typedef struct packed {
    logic timer16_0_trigger;
    logic timer16_1_trigger;
    logic func_timer0_trigger;
    logic func_timer1_trigger;
    logic time_base_interrupt;
  } asl_trig_t;

  // whole state of the block
  typedef struct packed {
    logic [15:0] chan_en_low;
    logic [1:0]  chan_en_high;
    logic [15:0] interval;
    logic [8:0]  mode;
    logic        run_flag;
    logic        trigger_start_enable;
    logic [1:0]  limit_condition_select;
    logic        limit_detect_enable;
    logic [9:0]  upper_bound_value;
    logic [9:0]  lower_bound_value;
    logic [1:0]  reference_source_select;
    logic        internal_reference_enable;
    logic        interrupt_timing_select;
    logic [4:0]  trigger_source_select;
    logic [1:0]  self_test_input_select;
    logic [16:0] limit_match_status;
    logic [15:0] result;
    logic [4:0]  channel;
    logic [15:0] gap_cnt;
    asl_state_t  state;
    logic [15:0] rdata;
    logic        int_req;
    logic        conv_start;
  } asl_regs_t;

endpackage : asl_pkg

/* asl_scan_ctrl.sv */
// scan sequencer, interval timer, limit compare and register file of the converter control
`timescale 1ns/10ps
`default_nettype none
`include "asl_consts.svh"

module asl_scan_ctrl
  import asl_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rst_b,
  input  wire asl_bus_req_t  bus_req,
  output logic [15:0]        bus_rdata,
  input  wire asl_trig_t     trig,
  output asl_conv_req_t      conv_req,
  input  wire asl_conv_rsp_t conv_rsp,
  output logic               int_req
);

  asl_regs_t r_q;
  asl_regs_t r_d;

  // lowest enabled channel at or above a start point; bit 5 says one was found
  function automatic logic [5:0] asl_pick(input logic [17:0] en, input logic [4:0] from);
    logic [5:0] res;
    res = 6'h00;
    for (int i = 17; i >= 0; i--) begin
      if (en[i] && (5'(i) >= from)) begin
        res = {1'b1, 5'(i)};
      end
    end
    return res;
  endfunction : asl_pick

  // limit test on the ten significant bits of a left-aligned result
  function automatic logic asl_match(input logic [1:0] cond, input logic [9:0] val,
                                     input logic [9:0] up, input logic [9:0] lo);
    logic m;
    m = 1'b0;
    case (cond)
      2'h0: m = (lo <= val) && (val <= up);
      2'h1: m = val > up;
      2'h2: m = val > lo;
      default: m = (val > up) || (val < lo);
    endcase
    return m;
  endfunction : asl_match

  logic [17:0] chan_en;
  logic        any_en;
  logic        trig_hit;
  logic [5:0]  first_pick;
  logic [5:0]  next_pick;
  logic        hit;
  logic [16:0] status_set;
  logic [16:0] status_clr;
  logic        scan_end;
  logic [15:0] rd_mux;

  // channel 16 and 17 sit above the sixteen pin channels
  assign chan_en    = {r_q.chan_en_high, r_q.chan_en_low};
  assign any_en     = |chan_en;
  assign first_pick = asl_pick(chan_en, 5'h00);
  assign next_pick  = asl_pick(chan_en, r_q.channel + 5'h01);

  // trigger source decode; reserved codes never fire
  always_comb begin
    case (r_q.trigger_source_select)
      `ASL_TRG_TMH0: trig_hit = trig.timer16_0_trigger;
      `ASL_TRG_TMH1: trig_hit = trig.timer16_1_trigger;
      `ASL_TRG_FTM0: trig_hit = trig.func_timer0_trigger;
      `ASL_TRG_FTM1: trig_hit = trig.func_timer1_trigger;
      `ASL_TRG_TBC:  trig_hit = trig.time_base_interrupt;
      default:       trig_hit = 1'b0;
    endcase
  end

  // a finished conversion in the current scan, ignored once the scan was stopped
  assign hit = conv_rsp.done && (r_q.state == st_busy);
  assign scan_end = hit && !next_pick[5];

  // status bits: hardware set beats software clear in the same cycle
  genvar g;
  generate
    for (g = 0; g < 17; g++) begin : g_status
      assign status_set[g] = hit && r_q.limit_detect_enable && (r_q.channel == 5'(g)) &&
                             asl_match(r_q.limit_condition_select, conv_rsp.result[15:6],
                                       r_q.upper_bound_value, r_q.lower_bound_value);
    end
  endgenerate

  always_comb begin
    status_clr = 17'h00000;
    if (bus_req.wr && (bus_req.addr == `ASL_OFF_STATUS_LOW)) begin
      status_clr[15:0] = bus_req.wdata;
    end else if (bus_req.wr && (bus_req.addr == `ASL_OFF_STATUS_HIGH)) begin
      status_clr[16] = bus_req.wdata[0];
    end
  end

  // read decode, answered one cycle after the strobe
  always_comb begin
    rd_mux = 16'h0000;
    if (bus_req.addr == `ASL_OFF_SELF_TEST) begin
      rd_mux = {14'h0000, r_q.self_test_input_select};
    end else if (bus_req.addr == `ASL_OFF_RESULT) begin
      rd_mux = r_q.result;
    end else if (bus_req.addr == `ASL_OFF_STATUS_LOW) begin
      rd_mux = r_q.limit_match_status[15:0];
    end else if (bus_req.addr == `ASL_OFF_STATUS_HIGH) begin
      rd_mux = {15'h0000, r_q.limit_match_status[16]};
    end else if (bus_req.addr == `ASL_OFF_MODE) begin
      rd_mux = {7'h00, r_q.mode};
    end else if (bus_req.addr == `ASL_OFF_CONTROL) begin
      rd_mux = {14'h0000, r_q.trigger_start_enable, r_q.run_flag};
    end else if (bus_req.addr == `ASL_OFF_EN_LOW) begin
      rd_mux = r_q.chan_en_low;
    end else if (bus_req.addr == `ASL_OFF_EN_HIGH) begin
      rd_mux = {14'h0000, r_q.chan_en_high};
    end else if (bus_req.addr == `ASL_OFF_INTERVAL) begin
      rd_mux = r_q.interval;
    end else if (bus_req.addr == `ASL_OFF_LIMIT_MODE) begin
      rd_mux = {6'h00, r_q.limit_condition_select, 7'h00, r_q.limit_detect_enable};
    end else if (bus_req.addr == `ASL_OFF_UPPER) begin
      rd_mux = {r_q.upper_bound_value, 6'h00};
    end else if (bus_req.addr == `ASL_OFF_LOWER) begin
      rd_mux = {r_q.lower_bound_value, 6'h00};
    end else if (bus_req.addr == `ASL_OFF_REF_CTRL) begin
      rd_mux = {10'h000, r_q.reference_source_select, 3'h0, r_q.internal_reference_enable};
    end else if (bus_req.addr == `ASL_OFF_INT_MODE) begin
      rd_mux = {15'h0000, r_q.interrupt_timing_select};
    end else if (bus_req.addr == `ASL_OFF_TRIG_SEL) begin
      rd_mux = {11'h000, r_q.trigger_source_select};
    end
  end

  // next state of the whole block
  always_comb begin
    logic start_req;
    logic stop_req;
    logic repeat_now;
    start_req  = 1'b0;
    stop_req   = 1'b0;
    repeat_now = 1'b0;
    r_d        = r_q;
    r_d.int_req    = 1'b0;
    r_d.conv_start = 1'b0;
    r_d.rdata      = bus_req.rd ? rd_mux : 16'h0000;

    // software register writes
    if (bus_req.wr) begin
      if (bus_req.addr == `ASL_OFF_SELF_TEST) begin
        r_d.self_test_input_select = bus_req.wdata[1:0];
      end else if (bus_req.addr == `ASL_OFF_MODE) begin
        r_d.mode = bus_req.wdata[8:0];
      end else if (bus_req.addr == `ASL_OFF_CONTROL) begin
        r_d.trigger_start_enable = bus_req.wdata[`ASL_BIT_TRIG_EN];
        start_req = bus_req.wdata[`ASL_BIT_RUN];
        stop_req  = !bus_req.wdata[`ASL_BIT_RUN];
      end else if (bus_req.addr == `ASL_OFF_EN_LOW) begin
        r_d.chan_en_low = bus_req.wdata;
      end else if (bus_req.addr == `ASL_OFF_EN_HIGH) begin
        r_d.chan_en_high = bus_req.wdata[1:0];
      end else if (bus_req.addr == `ASL_OFF_INTERVAL) begin
        r_d.interval = bus_req.wdata;
      end else if (bus_req.addr == `ASL_OFF_LIMIT_MODE) begin
        r_d.limit_condition_select = bus_req.wdata[`ASL_LIM_COND_LSB +: 2];
        r_d.limit_detect_enable    = bus_req.wdata[`ASL_LIM_EN_BIT];
      end else if (bus_req.addr == `ASL_OFF_UPPER) begin
        r_d.upper_bound_value = bus_req.wdata[15:`ASL_LIMIT_LSB];
      end else if (bus_req.addr == `ASL_OFF_LOWER) begin
        r_d.lower_bound_value = bus_req.wdata[15:`ASL_LIMIT_LSB];
      end else if (bus_req.addr == `ASL_OFF_REF_CTRL) begin
        r_d.reference_source_select   = bus_req.wdata[`ASL_REF_SEL_LSB +: 2];
        r_d.internal_reference_enable = bus_req.wdata[`ASL_REF_EN_BIT];
      end else if (bus_req.addr == `ASL_OFF_INT_MODE) begin
        r_d.interrupt_timing_select = bus_req.wdata[0];
      end else if (bus_req.addr == `ASL_OFF_TRIG_SEL) begin
        r_d.trigger_source_select = bus_req.wdata[4:0];
      end
    end

    // a trigger starts a scan only while enabled and idle
    if (r_q.trigger_start_enable && trig_hit && !r_q.run_flag) begin
      start_req = 1'b1;
    end

    r_d.limit_match_status = (r_q.limit_match_status & ~status_clr) | status_set;

    // sequencer
    case (r_q.state)
      st_idle: begin
        r_d.gap_cnt = 16'h0000;
      end
      st_launch: begin
        r_d.conv_start = 1'b1;
        r_d.state      = st_busy;
      end
      st_busy: begin
        if (hit) begin
          r_d.result = conv_rsp.result;
          if (!r_q.limit_detect_enable && r_q.interrupt_timing_select) begin
            r_d.int_req = 1'b1;
          end
          if (next_pick[5]) begin
            r_d.channel = next_pick[4:0];
            r_d.state   = st_launch;
          end else begin
            if (r_q.limit_detect_enable) begin
              r_d.int_req = |r_d.limit_match_status;
            end else if (!r_q.interrupt_timing_select) begin
              r_d.int_req = 1'b1;
            end
            if (r_q.mode[`ASL_BIT_REPEAT]) begin
              repeat_now = (r_q.mode[`ASL_MODE_CLK_LSB +: 3] == `ASL_CLK_SLOW) ||
                           (r_q.interval == 16'h0000);
              r_d.channel = first_pick[4:0];
              r_d.gap_cnt = r_q.interval;
              r_d.state   = repeat_now ? st_launch : st_gap;
            end else begin
              r_d.run_flag = 1'b0;
              r_d.state    = st_idle;
            end
          end
        end
      end
      st_gap: begin
        // one count down per fast clock cycle from the programmed value; launch when the count reaches one
        r_d.gap_cnt = r_q.gap_cnt - 16'h0001;
        if (r_q.gap_cnt == 16'h0001) begin
          r_d.state = st_launch;
        end
      end
      default: begin
        r_d.state = st_idle;
      end
    endcase

    // a new enable set applies from the next channel pick, even inside a running scan; an empty set cannot start
    if (start_req && !r_q.run_flag && any_en) begin
      r_d.run_flag = 1'b1;
      r_d.channel  = first_pick[4:0];
      r_d.state    = st_launch;
    end
    // stop wins over an ongoing scan; a late core answer is dropped in idle
    if (stop_req) begin
      r_d.run_flag   = 1'b0;
      r_d.state      = st_idle;
      r_d.conv_start = 1'b0;
      r_d.int_req    = 1'b0;
    end
  end

  // single register stage for all state
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      r_q                   <= '0;
      r_q.upper_bound_value <= `ASL_RST_UPPER;
      r_q.lower_bound_value <= `ASL_RST_LOWER;
      r_q.state             <= st_idle;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs toward bus, core and interrupt controller
  assign bus_rdata           = r_q.rdata;
  assign int_req             = r_q.int_req;
  assign conv_req.start      = r_q.conv_start;
  assign conv_req.channel    = r_q.channel;
  assign conv_req.test_sel   = r_q.self_test_input_select;
  // code 11 is not a fourth reference, it falls back to the supply pin
  assign conv_req.ref_sel    = (r_q.reference_source_select == 2'h3) ? 2'h0
                               : r_q.reference_source_select;
  assign conv_req.ref_en     = r_q.internal_reference_enable;
  assign conv_req.clk_sel    = r_q.mode[`ASL_MODE_CLK_LSB +: 3];
  assign conv_req.sample_sel = r_q.mode[7:4];
  assign conv_req.discharge  = r_q.mode[8];

endmodule : asl_scan_ctrl
`default_nettype wire

/* asl_scan_ctrl_monitor.sv */
// port-level assertions for the scan and limit control, with its bind
`timescale 1ns/10ps
`default_nettype none
`include "asl_consts.svh"

module asl_scan_ctrl_monitor
  import asl_pkg::*;
(
  input wire logic          clock,
  input wire logic          rst_b,
  input wire asl_bus_req_t  bus_req,
  input wire logic [15:0]   bus_rdata,
  input wire asl_conv_req_t conv_req,
  input wire asl_conv_rsp_t conv_rsp,
  input wire logic          int_req
);
  logic [17:0] en_q;
  logic [1:0]  tst_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // shadows taken from the write strobe; whole-word writes only, so no byte lanes
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      en_q  <= 18'h00000;
      tst_q <= 2'h0;
    end else if (bus_req.wr) begin
      if (bus_req.addr == `ASL_OFF_EN_LOW) en_q[15:0] <= bus_req.wdata;
      if (bus_req.addr == `ASL_OFF_EN_HIGH) en_q[17:16] <= bus_req.wdata[1:0];
      if (bus_req.addr == `ASL_OFF_SELF_TEST) tst_q <= bus_req.wdata[1:0];
    end
  end

  // register reads answer in the cycle after the strobe
  AST_EN_LOW_READ: assert property (bus_req.rd && bus_req.addr == `ASL_OFF_EN_LOW |=> bus_rdata == en_q[15:0])
    else $error("enable low read mismatch");
  AST_EN_HIGH_READ: assert property (bus_req.rd && bus_req.addr == `ASL_OFF_EN_HIGH |=> bus_rdata == {14'h0000, en_q[17:16]})
    else $error("enable high read mismatch");
  AST_UPPER_RSVD: assert property (bus_req.rd && bus_req.addr == `ASL_OFF_UPPER |=> bus_rdata[5:0] == 6'h00)
    else $error("upper limit low bits not zero");
  AST_LOWER_RSVD: assert property (bus_req.rd && bus_req.addr == `ASL_OFF_LOWER |=> bus_rdata[5:0] == 6'h00)
    else $error("lower limit low bits not zero");
  // a start only names an enabled channel, with the chosen test input
  AST_START_ENABLED: assert property (conv_req.start |-> en_q[conv_req.channel])
    else $error("start on a disabled channel");
  AST_TEST_INPUT: assert property (conv_req.start |-> conv_req.test_sel == tst_q)
    else $error("test input differs from register");
  // a start request with nothing enabled must stay silent
  AST_EMPTY_NO_START: assert property (bus_req.wr && bus_req.addr == `ASL_OFF_CONTROL && bus_req.wdata[0]
    && en_q == 18'h00000 |=> !conv_req.start [*4]) else $error("start with no channel enabled");
  AST_REF_CODE: assert property (conv_req.ref_sel != 2'h3)
    else $error("reserved reference code reached core");
  AST_INT_AFTER_DONE: assert property (int_req |-> $past(conv_rsp.done))
    else $error("interrupt not one cycle after done");
endmodule : asl_scan_ctrl_monitor

bind asl_scan_ctrl asl_scan_ctrl_monitor u_asl_scan_ctrl_monitor (.clock(clock), .rst_b(rst_b),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .conv_req(conv_req), .conv_rsp(conv_rsp), .int_req(int_req));
`default_nettype wire

/* asl_conv_core_model.sv */
// behavioural analog converter core answering the scan control
`timescale 1ns/10ps
`default_nettype none

module asl_conv_core_model
  import asl_pkg::*;
#(
  parameter logic [9:0] VREF_TEN = 10'h1f0  // internal reference code, value arbitrary
)
(
  input  wire logic          clock,
  input  wire logic          rst_b,
  input  wire asl_conv_req_t conv_req,
  input  wire logic [3:0]    lat,
  output var asl_conv_rsp_t  conv_rsp
);
  logic [3:0]  cnt_q;
  logic        done_q;
  logic [15:0] last_q;
  logic [15:0] value;

  // measured value: a code made from the channel, or the forced test input
  always_comb begin
    case (conv_req.test_sel)
      2'h1:    value = 16'hffc0;
      2'h2:    value = 16'h0000;
      2'h3:    value = {VREF_TEN, 6'h00};
      default: value = {conv_req.channel, 5'h15, 6'h00};
    endcase
  end

  // conversion takes lat cycles; lat of 1 is the fastest the core can be
  always_ff @(posedge clock) begin
    done_q <= 1'b0;
    if (!rst_b) begin
      cnt_q  <= 4'h0;
      last_q <= 16'h0000;
    end else if (conv_req.start) begin
      cnt_q <= lat;
    end else if (cnt_q == 4'h1) begin
      cnt_q  <= 4'h0;
      done_q <= 1'b1;
      last_q <= value;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  // result only holds while done; otherwise the line shows garbage
  assign conv_rsp = {done_q, done_q ? last_q : ~last_q};
endmodule : asl_conv_core_model
`default_nettype wire

/* tb_asl_scan_ctrl.sv */
// self-checking testbench of the scan and limit control
`timescale 1ns/10ps
`default_nettype none
`include "asl_consts.svh"

module tb_asl_scan_ctrl
  import asl_pkg::*;
;
  localparam logic [15:0] CTL = `ASL_OFF_CONTROL, ENL = `ASL_OFF_EN_LOW, ENH = `ASL_OFF_EN_HIGH,
    RES = `ASL_OFF_RESULT, STL = `ASL_OFF_STATUS_LOW, STH = `ASL_OFF_STATUS_HIGH, MOD = `ASL_OFF_MODE;
  localparam logic [9:0]  VREF = 10'h1f0;
  localparam logic [15:0] RA [11] = '{`ASL_OFF_SELF_TEST, ENL, ENH, `ASL_OFF_INTERVAL, `ASL_OFF_LIMIT_MODE,
    `ASL_OFF_UPPER, `ASL_OFF_LOWER, `ASL_OFF_REF_CTRL, `ASL_OFF_INT_MODE, `ASL_OFF_TRIG_SEL, 16'hf830};
  localparam logic [15:0] RV [11] = '{0, 0, 0, 0, 0, 16'hffc0, 0, 0, 0, 0, 0};
  localparam logic [15:0] RM [11] = '{16'h0003, 16'hffff, 16'h0003, 16'hffff, 16'h0301, 16'hffc0, 16'hffc0,
    16'h0031, 16'h0001, 16'h001f, 16'h0000};
  localparam logic [15:0] SL [4] = '{16'h8001, 16'h0000, 16'h8000, 16'h0000};
  localparam logic [15:0] SH [4] = '{16'h0000, 16'h0001, 16'h0001, 16'h0001};
  localparam logic [15:0] ST [3] = '{16'hffc0, 16'h0000, {VREF, 6'h00}};
  localparam logic [4:0]  TC [6] = '{5'h00, 5'h01, 5'h04, 5'h05, 5'h08, 5'h02};
  localparam logic [4:0]  TV [6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h1f};
  localparam int          TE [6] = '{1, 1, 1, 1, 1, 0};
  localparam int          LIMIT = 20000;
  logic          clock;
  logic          rst_b;
  asl_bus_req_t  bus_req;
  logic [15:0]   bus_rdata;
  asl_trig_t     trig;
  asl_conv_req_t conv_req;
  asl_conv_rsp_t conv_rsp;
  logic          int_req;
  logic [3:0]    lat;
  logic          rd_d;
  logic [31:0]   e;
  logic [31:0]   rq [$];
  logic [15:0]   chq [$];
  logic [15:0]   r;
  int            failures, check_count, cyc, ints, starts, p1, p2, p3, i, s0;

  asl_scan_ctrl u_asl_scan_ctrl (.clock(clock), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .trig(trig), .conv_req(conv_req), .conv_rsp(conv_rsp), .int_req(int_req));
  asl_conv_core_model #(.VREF_TEN(VREF)) u_asl_conv_core_model (.clock(clock), .rst_b(rst_b),
    .conv_req(conv_req), .lat(lat), .conv_rsp(conv_rsp));

  always #50 clock = ~clock;

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // bus cycles: one strobe cycle, then an idle edge before the next request
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] v);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    rq.push_back({a, v});
    @(posedge clock);
    bus_req.rd <= 1'b0;
  endtask : rd

  task automatic pulse(input logic [4:0] v);
    @(posedge clock);
    trig <= v;
    @(posedge clock);
    trig <= 5'h00;
  endtask : pulse

  // counting interrupts after the fact also catches surplus pulses
  task automatic run_scan(input int n);
    int i0;
    int j;
    i0 = ints;
    wr(CTL, 16'h0001);
    for (j = 0; j < 3000 && ints < i0 + n; j++) @(posedge clock);
    repeat (30) @(posedge clock);
    chk("interrupt count", 16'(ints - i0), 16'(n));
  endtask : run_scan

  // start-to-start distance, skipping one start so a mode change has settled
  task automatic meas(output int p);
    int t0;
    int j;
    s0 = starts;
    for (j = 0; j < 500 && starts < s0 + 2; j++) @(posedge clock);
    t0 = cyc;
    for (j = 0; j < 500 && starts < s0 + 3; j++) @(posedge clock);
    p = cyc - t0;
  endtask : meas

  // watcher: read data, channel order, event counts and the overall time limit
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (rd_d) begin
      e = rq.pop_front();
      chk($sformatf("register %h", e[31:16]), bus_rdata, e[15:0]);
    end
    rd_d <= bus_req.rd;
    if (int_req === 1'b1) ints <= ints + 1;
    if (conv_req.start === 1'b1) begin
      starts <= starts + 1;
      if (chq.size() > 0) chk("channel", 16'(conv_req.channel), chq.pop_front());
    end
    if (cyc == LIMIT) begin
      failures++;
      final_report();
    end
  end

  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    bus_req = '0;
    trig = '0;
    lat = 4'h3;
    rd_d = 1'b0;
    {failures, check_count, cyc, ints, starts} = '0;
    void'($urandom(32'hd9bd));
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    // reset values, then random words read back with reserved bits at zero
    for (i = 0; i < 11; i++) rd(RA[i], RV[i]);
    rd(CTL, 16'h0000);
    for (i = 0; i < 11; i++) begin
      r = 16'($urandom());
      wr(RA[i], r);
      rd(RA[i], r & RM[i]);
      wr(RA[i], RV[i]);
    end
    // three channels in ascending order, temperature channel last
    // code 11 must reach the core as the supply pin
    wr(`ASL_OFF_REF_CTRL, 16'h0031);
    @(posedge clock);
    chk("reference to core", 16'({conv_req.ref_sel, conv_req.ref_en}), 16'h0001);
    wr(`ASL_OFF_REF_CTRL, 16'h0021);
    @(posedge clock);
    chk("reference to core", 16'({conv_req.ref_sel, conv_req.ref_en}), 16'h0005);
    repeat (2000) @(posedge clock);
    wr(ENL, 16'h0024);
    wr(ENH, 16'h0001);
    chq = '{16'd2, 16'd5, 16'd16};
    run_scan(1);
    rd(CTL, 16'h0000);
    rd(RES, 16'h8540);
    rd(STL, 16'h0000);
    // start refused with nothing enabled
    wr(ENL, 16'h0000);
    wr(ENH, 16'h0000);
    s0 = starts;
    wr(CTL, 16'h0001);
    rd(CTL, 16'h0000);
    repeat (10) @(posedge clock);
    chk("start count", 16'(starts - s0), 16'h0000);
    // per-channel interrupts with a slow core
    lat <= 4'h9;
    wr(`ASL_OFF_INT_MODE, 16'h0001);
    wr(ENL, 16'h8001);
    chq = '{16'd0, 16'd15};
    run_scan(2);
    lat <= 4'h3;
    // every limit condition; results sit on the lower bound, between the bounds and above the upper bound
    wr(ENH, 16'h0001);
    wr(`ASL_OFF_LOWER, 16'h0540);
    wr(`ASL_OFF_UPPER, 16'h8000);
    for (i = 0; i < 4; i++) begin
      wr(`ASL_OFF_LIMIT_MODE, {6'h00, 2'(i), 7'h00, 1'b1});
      run_scan(1);
      wr(STL, 16'h0000);
      wr(STH, 16'h0000);
      rd(STL, SL[i]);
      rd(STH, SH[i]);
      wr(STL, 16'hffff);
      wr(STH, 16'h0001);
      rd(STL, 16'h0000);
    end
    wr(`ASL_OFF_LIMIT_MODE, 16'h0000);
    wr(`ASL_OFF_INT_MODE, 16'h0000);
    wr(ENH, 16'h0000);
    wr(ENL, 16'h0001);
    // forced test inputs land in the result register
    for (i = 1; i < 4; i++) begin
      wr(`ASL_OFF_SELF_TEST, 16'(i));
      run_scan(1);
      rd(RES, ST[i-1]);
    end
    wr(`ASL_OFF_SELF_TEST, 16'h0000);
    // repeated scans: programmed gap, slow clock override, zero gap
    wr(`ASL_OFF_INTERVAL, 16'd20);
    wr(MOD, 16'h0001);
    wr(CTL, 16'h0001);
    meas(p1);
    wr(MOD, 16'h000f);
    @(posedge clock);
    chk("clock select", 16'(conv_req.clk_sel), 16'h0007);
    meas(p2);
    wr(`ASL_OFF_INTERVAL, 16'h0000);
    wr(MOD, 16'h0001);
    meas(p3);
    chk("interval", 16'(p1 - p2), 16'd20);
    chk("zero interval", 16'(p3), 16'(p2));
    rd(CTL, 16'h0001);
    wr(CTL, 16'h0000);
    rd(CTL, 16'h0000);
    wr(MOD, 16'h0000);
    // each trigger source, first with triggers disabled, then after a pulse on all other sources
    for (i = 0; i < 6; i++) begin
      wr(`ASL_OFF_TRIG_SEL, 16'(TC[i]));
      wr(CTL, 16'h0000);
      s0 = starts;
      pulse(TV[i]);
      wr(CTL, 16'h0002);
      pulse(~TV[i]);
      pulse(TV[i]);
      repeat (40) @(posedge clock);
      chk("trigger start", 16'(starts - s0), 16'(TE[i]));
    end
    final_report();
  end
endmodule : tb_asl_scan_ctrl
`default_nettype wire
